/* rtl/sample_clock_delay_detect_ctrl.sv */
// Purpose: Register control of sample clock delay, clock presence, duty cycle stabilizer and sync flags
// Assumes: Avalon-MM slave with one wait state; sync error pulses come from core_clk logic
// Notes: Registers hold up to 8 bits in the low byte lane; upper bits read as zero
`timescale 1ns/1ps
`default_nettype none
`include "clk_cond_defs.svh"

module sample_clock_delay_detect_ctrl (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire clk_cond_pkg::bus_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire clk_cond_pkg::bus_data_t avs_writedata,
  input wire clk_cond_pkg::bus_be_t avs_byteenable,
  output clk_cond_pkg::bus_data_t avs_readdata,
  output logic avs_waitrequest,
  input wire logic sample_div_in,
  input wire logic setup_err_pulse,
  input wire logic hold_err_pulse,
  output clk_cond_pkg::reg_byte_t fine_delay_steps,
  output clk_cond_pkg::reg_byte_t superfine_delay_steps,
  output logic dcs_power_up,
  output logic dcs_active,
  output logic setup_err_flag,
  output logic hold_err_flag,
  output logic irq
);
  import clk_cond_pkg::*;

  delay_mode_t delay_mode_reg;
  reg_byte_t superfine_reg;
  reg_byte_t fine_reg;
  reg_byte_t pres_ctrl_reg;
  reg_byte_t dcs_ctrl_reg;
  logic flag_rst_reg;
  logic [3:0] irq_status_reg;
  logic [3:0] irq_mask_reg;
  logic done_reg;
  logic clk_detected;
  logic detected_d_reg;
  logic [9:0] idx;
  logic wr_en;
  logic rd_en;
  logic [3:0] events;
  reg_byte_t fine_next;
  reg_byte_t superfine_next;
  reg_byte_t rd_next;

  function automatic reg_byte_t clamp(input reg_byte_t v, input reg_byte_t lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  // ==========================================
  // Avalon slave handshake: one wait state per access
  assign idx = avs_address[11:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~done_reg;
  assign wr_en = avs_write & done_reg & avs_byteenable[0];
  assign rd_en = avs_read & ~done_reg;

  // Done clears after the answer: two cycles per access
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (avs_read | avs_write) & ~done_reg;
    end
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_mode_reg <= `RST_DELAY_MODE;
      superfine_reg <= `RST_SUPERFINE;
      fine_reg <= `RST_FINE;
      pres_ctrl_reg <= `RST_PRES_CTRL;
      dcs_ctrl_reg <= `RST_DCS_CTRL;
      flag_rst_reg <= 1'b0;
      irq_mask_reg <= `RST_IRQ;
    end else if (wr_en) begin
      case (idx)
        `IDX_DELAY_MODE: delay_mode_reg <= avs_writedata[2:0];
        `IDX_SUPERFINE: superfine_reg <= avs_writedata[7:0];
        `IDX_FINE: fine_reg <= avs_writedata[7:0];
        `IDX_PRES_CTRL: pres_ctrl_reg <= avs_writedata[7:0];
        `IDX_DCS_CTRL: dcs_ctrl_reg <= avs_writedata[7:0];
        `IDX_SYNC_CTRL1: flag_rst_reg <= avs_writedata[`POS_FLAG_RST];
        `IDX_IRQ_MASK: irq_mask_reg <= avs_writedata[3:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // Read data mux
  always_comb begin
    rd_next = 8'h00;
    case (idx)
      `IDX_DELAY_MODE: rd_next = {5'h00, delay_mode_reg};
      `IDX_SUPERFINE: rd_next = superfine_reg;
      `IDX_FINE: rd_next = fine_reg;
      `IDX_PRES_CTRL: rd_next = pres_ctrl_reg;
      `IDX_PRES_STAT: rd_next = {7'h00, clk_detected};
      `IDX_DCS_CTRL: rd_next = dcs_ctrl_reg;
      `IDX_SYNC_CTRL1: rd_next = {1'b0, flag_rst_reg, 6'h00};
      `IDX_SYNC_FLAGS: rd_next = {6'h00, hold_err_flag, setup_err_flag};
      `IDX_IRQ_STATUS: rd_next = {4'h0, irq_status_reg};
      `IDX_IRQ_MASK: rd_next = {4'h0, irq_mask_reg};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_en) begin
      avs_readdata <= {24'h00_0000, rd_next};
    end
  end

  // ==========================================
  // Delay mode decode
  always_comb begin
    fine_next = 8'h00;
    superfine_next = 8'h00;
    case (delay_mode_reg)
      `MODE_NONE: fine_next = 8'h00;
      `MODE_FINE_LOW, `MODE_FINE_LOW_JIT: fine_next = clamp(fine_reg, `FINE_LOW_MAX);
      `MODE_FINE_ALL, `MODE_FINE_ALL_B: fine_next = clamp(fine_reg, `FINE_MAX);
      `MODE_FINE_SUPER: begin
        fine_next = clamp(fine_reg, `FINE_MAX);
        superfine_next = clamp(superfine_reg, `SUPERFINE_MAX);
      end
      // Reserved codes 001 and 111 give no delay
      default: fine_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fine_delay_steps <= 8'h00;
      superfine_delay_steps <= 8'h00;
    end else begin
      fine_delay_steps <= fine_next;
      superfine_delay_steps <= superfine_next;
    end
  end

  // ==========================================
  // Duty cycle stabilizer: active only while powered
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dcs_power_up <= 1'b0;
      dcs_active <= 1'b0;
    end else begin
      dcs_power_up <= dcs_ctrl_reg[`POS_DCS_PWR];
      dcs_active <= dcs_ctrl_reg[`POS_DCS_EN] & dcs_ctrl_reg[`POS_DCS_PWR];
    end
  end

  // ==========================================
  // Clock presence detection
  clk_presence_detector u_detector (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sample_div_in(sample_div_in),
    .enable(pres_ctrl_reg[`POS_PRES_EN]),
    .low_rate_sel(pres_ctrl_reg[`POS_PRES_THR_HI]),
    .detected(clk_detected)
  );

  // ==========================================
  // Sync error flags: held clear during flag reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_err_flag <= 1'b0;
      hold_err_flag <= 1'b0;
    end else if (flag_rst_reg) begin
      setup_err_flag <= 1'b0;
      hold_err_flag <= 1'b0;
    end else begin
      setup_err_flag <= setup_err_flag | setup_err_pulse;
      hold_err_flag <= hold_err_flag | hold_err_pulse;
    end
  end

  // ==========================================
  // Interrupt status, set wins over clear
  assign events = {hold_err_pulse & ~flag_rst_reg, setup_err_pulse & ~flag_rst_reg,
                   detected_d_reg & ~clk_detected, clk_detected & ~detected_d_reg};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      detected_d_reg <= 1'b0;
      irq_status_reg <= `RST_IRQ;
    end else begin
      detected_d_reg <= clk_detected;
      if (wr_en && idx == `IDX_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~avs_writedata[3:0]) | events;
      end else begin
        irq_status_reg <= irq_status_reg | events;
      end
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ==========================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  superfine_gate_a: assert property (
    delay_mode_reg != `MODE_FINE_SUPER |=> superfine_delay_steps == 8'h00)
    else $error("super fine delay active outside mode 110");
  superfine_value_a: assert property (
    delay_mode_reg == `MODE_FINE_SUPER && superfine_reg <= `SUPERFINE_MAX
    |=> superfine_delay_steps == $past(superfine_reg))
    else $error("super fine delay does not follow its field");
  fine_full_a: assert property (
    delay_mode_reg == `MODE_FINE_ALL && fine_reg <= `FINE_MAX |=> fine_delay_steps == $past(fine_reg))
    else $error("fine delay does not follow its field in full mode");
  fine_none_a: assert property (
    delay_mode_reg == `MODE_NONE |=> fine_delay_steps == 8'h00)
    else $error("delay applied in mode 000");
  fine_low_a: assert property (
    (delay_mode_reg == `MODE_FINE_LOW || delay_mode_reg == `MODE_FINE_LOW_JIT) && fine_reg > `FINE_LOW_MAX
    |=> fine_delay_steps == `FINE_LOW_MAX)
    else $error("low fine mode exceeds step 16");
  status_read_a: assert property (
    rd_en && idx == `IDX_PRES_STAT |=> avs_readdata == {24'h00_0000, 7'h00, $past(clk_detected)})
    else $error("clock status read mismatch");
  dcs_order_a: assert property (
    dcs_active |-> dcs_power_up)
    else $error("stabilizer active while powered down");
  flag_hold_a: assert property (
    flag_rst_reg |=> !setup_err_flag && !hold_err_flag)
    else $error("sync error flag set during flag reset");
  detect_off_a: assert property (
    !pres_ctrl_reg[`POS_PRES_EN] |=> !clk_detected)
    else $error("clock detected while detection disabled");

  fine_low_pass_a: assert property (
    (delay_mode_reg == `MODE_FINE_LOW || delay_mode_reg == `MODE_FINE_LOW_JIT) && fine_reg <= `FINE_LOW_MAX
    |=> fine_delay_steps == $past(fine_reg))
    else $error("low fine mode does not follow its field");
  fine_super_a: assert property (
    delay_mode_reg == `MODE_FINE_SUPER && fine_reg <= `FINE_MAX |=> fine_delay_steps == $past(fine_reg))
    else $error("fine delay does not follow its field in mode 110");
  fine_clamp_a: assert property (
    (delay_mode_reg == `MODE_FINE_ALL || delay_mode_reg == `MODE_FINE_ALL_B || delay_mode_reg == `MODE_FINE_SUPER)
    && fine_reg > `FINE_MAX |=> fine_delay_steps == `FINE_MAX)
    else $error("fine delay beyond step 192");
  superfine_clamp_a: assert property (
    delay_mode_reg == `MODE_FINE_SUPER && superfine_reg > `SUPERFINE_MAX
    |=> superfine_delay_steps == `SUPERFINE_MAX)
    else $error("super fine delay beyond step 128");
  dcs_bypass_a: assert property (
    !dcs_ctrl_reg[`POS_DCS_EN] |=> !dcs_active)
    else $error("stabilizer active while bypassed");
  dcs_power_a: assert property (
    dcs_ctrl_reg[`POS_DCS_PWR] |=> dcs_power_up)
    else $error("stabilizer not powered while its power bit is set");
  dcs_enable_a: assert property (
    dcs_ctrl_reg[`POS_DCS_EN] && dcs_ctrl_reg[`POS_DCS_PWR] |=> dcs_active)
    else $error("stabilizer bypassed while powered and enabled");
  setup_set_a: assert property (
    !flag_rst_reg && setup_err_pulse |=> setup_err_flag)
    else $error("setup error pulse lost");
  hold_set_a: assert property (
    !flag_rst_reg && hold_err_pulse |=> hold_err_flag)
    else $error("hold error pulse lost");
  detect_rise_a: assert property (
    clk_detected && !detected_d_reg |=> irq_status_reg[`IRQ_DET_RISE])
    else $error("detect rise event lost");
  detect_fall_a: assert property (
    !clk_detected && detected_d_reg |=> irq_status_reg[`IRQ_DET_FALL])
    else $error("detect fall event lost");
  setup_event_a: assert property (
    setup_err_pulse && !flag_rst_reg |=> irq_status_reg[`IRQ_SETUP_ERR])
    else $error("setup error event lost");
  bus_answer_a: assert property (
    avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  read_upper_a: assert property (
    rd_en |=> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");

  detect_seen_c: cover property (detected_d_reg == 1'b0 ##1 clk_detected);
  super_mode_c: cover property (superfine_delay_steps != 8'h00);
  irq_seen_c: cover property (irq ##[1:20] !irq);
  flag_reset_c: cover property (flag_rst_reg && (setup_err_pulse || hold_err_pulse));
  low_rate_c: cover property (pres_ctrl_reg[`POS_PRES_THR_HI] && clk_detected);
endmodule
`default_nettype wire

/* rtl/clk_cond_defs.svh */
// Purpose: Offsets, reset values, field positions and timing counts of the sample clock control block
// Assumes: Register index times four gives the Avalon byte address
// Notes: Definitions only
`ifndef CLK_COND_DEFS_SVH
`define CLK_COND_DEFS_SVH

// ==========================================
// Register indices
`define IDX_DELAY_MODE 10'h110
`define IDX_SUPERFINE 10'h111
`define IDX_FINE 10'h112
`define IDX_PRES_CTRL 10'h11A
`define IDX_PRES_STAT 10'h11B
`define IDX_DCS_CTRL 10'h11C
`define IDX_SYNC_CTRL1 10'h120
`define IDX_SYNC_FLAGS 10'h128
`define IDX_IRQ_STATUS 10'h130
`define IDX_IRQ_MASK 10'h131

// ==========================================
// Reset values
`define RST_DELAY_MODE 3'h0
`define RST_SUPERFINE 8'h00
`define RST_FINE 8'hC0
`define RST_PRES_CTRL 8'h0C
`define RST_DCS_CTRL 8'h08
`define RST_IRQ 4'h0

// ==========================================
// Field positions
`define POS_PRES_EN 2
`define POS_PRES_THR_HI 4
`define POS_DCS_PWR 0
`define POS_DCS_EN 1
`define POS_FLAG_RST 6
`define IRQ_DET_RISE 0
`define IRQ_DET_FALL 1
`define IRQ_SETUP_ERR 2
`define IRQ_HOLD_ERR 3

// ==========================================
// Delay modes and limits
`define MODE_NONE 3'h0
`define MODE_FINE_LOW 3'h2
`define MODE_FINE_LOW_JIT 3'h3
`define MODE_FINE_ALL 3'h4
`define MODE_FINE_ALL_B 3'h5
`define MODE_FINE_SUPER 3'h6
`define FINE_MAX 8'hC0
`define FINE_LOW_MAX 8'h10
`define SUPERFINE_MAX 8'h80

// ==========================================
// Clock presence timing
`define CORE_CLK_MHZ 250
`define DET_WINDOW_NS 1024
`define DET_WINDOW_CYCLES ((`DET_WINDOW_NS * `CORE_CLK_MHZ) / 1000)
`define DET_PRESCALE 8
`define DET_THR_LO_MHZ 200
`define DET_THR_HI_MHZ 150
`define DET_EDGES(mhz) (((mhz) * `DET_WINDOW_NS) / (1000 * `DET_PRESCALE))

`endif

/* rtl/clk_cond_pkg.sv */
// Purpose: Shared types of the sample clock control block
// Assumes: Nothing
// Notes: Constants live in clk_cond_defs.svh
package clk_cond_pkg;
  typedef logic [11:0] bus_addr_t;
  typedef logic [31:0] bus_data_t;
  typedef logic [3:0] bus_be_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [2:0] delay_mode_t;
endpackage

/* rtl/clk_presence_detector.sv */
// Purpose: Decides whether the divided sample clock runs above a chosen rate
// Assumes: sample_div_in toggles once per DET_PRESCALE sample clock cycles
// Notes: Verdict refreshed once per counting window
`timescale 1ns/1ps
`default_nettype none
`include "clk_cond_defs.svh"

module clk_presence_detector #(
  parameter int WIN_CYCLES = `DET_WINDOW_CYCLES,
  parameter int EDGES_LO = `DET_EDGES(`DET_THR_LO_MHZ),
  parameter int EDGES_HI = `DET_EDGES(`DET_THR_HI_MHZ)
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sample_div_in,
  input wire logic enable,
  input wire logic low_rate_sel,
  output logic detected
);
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic [15:0] win_reg;
  logic [15:0] edge_reg;
  logic [15:0] thr;

  // ==========================================
  // Two-stage synchroniser and edge tap
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= sample_div_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign thr = low_rate_sel ? 16'(EDGES_HI) : 16'(EDGES_LO);

  // ==========================================
  // Window count and verdict
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_reg <= 16'h0000;
      edge_reg <= 16'h0000;
      detected <= 1'b0;
    end else if (!enable) begin
      win_reg <= 16'h0000;
      edge_reg <= 16'h0000;
      detected <= 1'b0;
    end else if (win_reg == 16'(WIN_CYCLES - 1)) begin
      win_reg <= 16'h0000;
      edge_reg <= 16'h0000;
      detected <= (edge_reg >= thr);
    end else begin
      win_reg <= win_reg + 16'h0001;
      if (sync2_reg != sync3_reg) begin
        edge_reg <= edge_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* test/sample_clk_source.sv */
// Purpose: Model of the external sample clock as seen after the divide by eight
// Assumes: Rate given in MHz; run low or zero rate stops the clock
// Notes: Output toggles once per eight sample clock periods
`timescale 1ns/1ps
`default_nettype none

module sample_clk_source (
  input wire logic run,
  input wire logic [15:0] freq_mhz,
  output logic div_out
);
  initial div_out = 1'b0;
  // ==========================================
  // Divided clock, stands still when stopped
  always begin
    if (run && freq_mhz != 16'h0000) begin
      #(8000.0 / freq_mhz);
      div_out = ~div_out;
    end else begin
      #1;
    end
  end
endmodule
`default_nettype wire

/* test/sample_clock_delay_detect_ctrl_tb.sv */
// Purpose: Self-checking bench of the sample clock control block
// Assumes: Slave answers through waitrequest; detector window of 256 cycles
// Notes: Presence waits cover three windows
`timescale 1ns/1ps
`default_nettype none
`include "clk_cond_defs.svh"

module sample_clock_delay_detect_ctrl_tb;
  import clk_cond_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  bus_addr_t avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  bus_data_t avs_writedata = 32'h0000_0000;
  bus_be_t avs_byteenable = 4'hF;
  bus_data_t avs_readdata;
  logic avs_waitrequest, sample_div_in, dcs_power_up, dcs_active, setup_err_flag, hold_err_flag, irq;
  logic setup_err_pulse = 1'b0;
  logic hold_err_pulse = 1'b0;
  reg_byte_t fine_delay_steps, superfine_delay_steps;
  logic src_run = 1'b0;
  logic [15:0] src_mhz = 16'h0000;
  int n_fail = 0;
  int num_checks = 0;

  always #2 core_clk = ~core_clk;

  sample_clock_delay_detect_ctrl u_dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_div_in(sample_div_in),
    .setup_err_pulse(setup_err_pulse), .hold_err_pulse(hold_err_pulse), .fine_delay_steps(fine_delay_steps),
    .superfine_delay_steps(superfine_delay_steps), .dcs_power_up(dcs_power_up), .dcs_active(dcs_active),
    .setup_err_flag(setup_err_flag), .hold_err_flag(hold_err_flag), .irq(irq));

  sample_clk_source u_src (.run(src_run), .freq_mhz(src_mhz), .div_out(sample_div_in));

  // ==========================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d, input bus_be_t be,
                     output bus_data_t q);
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus_data_t q;
    bus(1'b1, idx, d, 4'hF, q);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string name);
    bus_data_t q;
    bus(1'b0, idx, 8'h00, 4'hF, q);
    chk(name, q, exp);
  endtask

  task automatic pulse(input logic s);
    @(posedge core_clk);
    setup_err_pulse <= s;
    hold_err_pulse <= !s;
    @(posedge core_clk);
    setup_err_pulse <= 1'b0;
    hold_err_pulse <= 1'b0;
    @(negedge core_clk);
  endtask

  function automatic logic [7:0] exp_fine(input logic [2:0] m, input logic [7:0] f);
    case (m)
      3'h2, 3'h3: return (f > 8'h10) ? 8'h10 : f;
      3'h4, 3'h5, 3'h6: return (f > 8'hC0) ? 8'hC0 : f;
      default: return 8'h00;
    endcase
  endfunction

  // ==========================================
  // Scenarios
  task automatic t_reset();
    bus_data_t q;
    rd_chk(`IDX_SUPERFINE, 32'h0000_0000, "superfine");
    rd_chk(`IDX_FINE, 32'h0000_00C0, "fine");
    rd_chk(`IDX_PRES_CTRL, 32'h0000_000C, "pres_ctrl");
    rd_chk(`IDX_DCS_CTRL, 32'h0000_0008, "dcs_ctrl");
    rd_chk(`IDX_SYNC_CTRL1, 32'h0000_0000, "sync_ctrl1");
    wr(`IDX_PRES_STAT, 8'hFF);
    rd_chk(`IDX_PRES_STAT, 32'h0000_0000, "pres_stat_ro");
    wr(10'h3FF, 8'h5A);
    rd_chk(10'h3FF, 32'h0000_0000, "unmapped");
    chk("fine_out_rst", fine_delay_steps, 32'h0000_0000);
  endtask

  task automatic t_modes();
    logic [7:0] fv [4] = '{8'h10, 8'h11, 8'hC0, 8'hFF};
    logic [7:0] sf;
    bus_data_t q;
    for (int m = 0; m < 8; m++) begin
      for (int i = 0; i < 4; i++) begin
        sf = 8'h7F + 8'(i);
        wr(`IDX_FINE, fv[i]);
        wr(`IDX_SUPERFINE, sf);
        wr(`IDX_DELAY_MODE, 8'(m));
        @(negedge core_clk);
        chk("fine_out", fine_delay_steps, exp_fine(3'(m), fv[i]));
        chk("sf_out", superfine_delay_steps, (m == 6) ? ((sf > 8'h80) ? 8'h80 : sf) : 8'h00);
      end
    end
    bus(1'b1, `IDX_FINE, 8'h05, 4'h0, q);
    rd_chk(`IDX_FINE, 32'h0000_00FF, "fine_be0");
  endtask

  task automatic t_dcs();
    logic [1:0] seq [4] = '{2'h1, 2'h3, 2'h1, 2'h0};
    for (int v = 0; v < 4; v++) begin
      wr(`IDX_DCS_CTRL, 8'h08 | {6'h00, seq[v]});
      @(negedge core_clk);
      chk("dcs_pwr", dcs_power_up, seq[v][0]);
      chk("dcs_act", dcs_active, seq[v][1]);
    end
  endtask

  task automatic presence(input logic [15:0] mhz, input logic [7:0] ctrl, input logic [31:0] exp);
    src_mhz <= mhz;
    src_run <= (mhz != 16'h0000);
    wr(`IDX_PRES_CTRL, ctrl);
    repeat (800) @(posedge core_clk);
    rd_chk(`IDX_PRES_STAT, exp, "pres_stat");
  endtask

  task automatic t_presence();
    presence(16'd300, 8'h0C, 32'h0000_0001);
    rd_chk(`IDX_IRQ_STATUS, 32'h0000_0001, "irq_rise");
    wr(`IDX_IRQ_MASK, 8'h01);
    chk("irq_on", irq, 1'b1);
    wr(`IDX_IRQ_STATUS, 8'h01);
    chk("irq_off", irq, 1'b0);
    presence(16'd300, 8'h08, 32'h0000_0000);
    rd_chk(`IDX_IRQ_STATUS, 32'h0000_0002, "irq_fall");
    presence(16'd170, 8'h0C, 32'h0000_0000);
    presence(16'd170, 8'h1C, 32'h0000_0001);
    presence(16'd0, 8'h1C, 32'h0000_0000);
    wr(`IDX_IRQ_STATUS, 8'h0F);
    rd_chk(`IDX_IRQ_STATUS, 32'h0000_0000, "irq_clr");
  endtask

  task automatic t_sync_irq();
    pulse(1'b1);
    chk("setup_flag", setup_err_flag, 1'b1);
    chk("hold_flag", hold_err_flag, 1'b0);
    wr(`IDX_SYNC_CTRL1, 8'h40);
    @(negedge core_clk);
    chk("setup_held", setup_err_flag, 1'b0);
    pulse(1'b0);
    chk("hold_held", hold_err_flag, 1'b0);
    rd_chk(`IDX_SYNC_CTRL1, 32'h0000_0040, "sync_ctrl1");
    wr(`IDX_SYNC_CTRL1, 8'h00);
    pulse(1'b0);
    chk("hold_flag2", hold_err_flag, 1'b1);
    rd_chk(`IDX_SYNC_FLAGS, 32'h0000_0002, "sync_flags");
    wr(`IDX_IRQ_MASK, 8'h04);
    chk("irq_setup", irq, 1'b1);
    wr(`IDX_IRQ_STATUS, 8'h04);
    chk("irq_masked", irq, 1'b0);
  endtask

  // ==========================================
  // Run control
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_modes();
    t_dcs();
    t_presence();
    t_sync_irq();
    final_report();
  end
endmodule
`default_nettype wire
